// *** verilog/amt_control.sv ***
// Purpose: converter mode, trigger, interrupt flag and DMA transfer control
// Assumes: single clock core_clk at 40 MHz, synchronous inputs
// Notes:   analog front end is modelled by sampled input words

`timescale 1ns/10ps

// Operation
// - clock gate bit 5 stops converter
// - mask bit zero passes, one blocks
// - request flag reads one when raised
// - 30-pin parts use high registers bit 0
// - mode bit 6 selects select or scan
// - frequency field divides fCLK per table
// - voltage mode gives 19 or 17 periods
// - trigger source field picks hardware event
// - repeat bit: zero sequential, one one-shot
// - trigger mode: software, no-wait, wait
// - start source 0001 uses conversion end
// - enabled pending channel waits for trigger
// - scan from channel value through slot 3
module amt_control
  import amt_pkg::*;
#(
  parameter int          RES_BITS = 10,
  parameter int          CHANNELS = 4,
  parameter logic        PINS_30  = 1'b0
) (
  // clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               resetn,
  // apb slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic                                    pready,
  output logic                                    pslverr,
  output logic [31:0]                             prdata,
  // analog samples and hardware triggers
  input  wire logic [CHANNELS-1:0][RES_BITS-1:0]  analogInput,
  input  wire logic                               timerCh1Event,
  input  wire logic                               rtcEvent,
  input  wire logic                               intervalTimerEvent,
  // converter status
  output logic                                    converterClockGate,
  output logic                                    conversionEndEvent,
  output logic                                    convEndIrq,
  output logic [1:0]                              activeChannel,
  // dma ram port and interrupts
  output amt_ram_wr_t                             ramWrite,
  output logic                                    dmaEndEvent,
  output logic                                    irq
);

  // ==========================================================================
  // registers
  logic [15:0] dmaTransferCount;
  logic [7:0]  perEnable, maskLow, flagLow, maskHigh, flagHigh;
  logic [7:0]  modeZero, modeOne, inputChannel, dmaCtrl, dmaMode;
  logic [15:0] dmaRamAddr, result;
  logic [1:0]  irqStatus, irqMask;
  amt_state_t  state;
  logic [6:0]  prescale;
  logic [4:0]  periodCount;
  logic [1:0]  slot;
  logic        clearStart;

  logic        wrEn, hwEvent, gateOn, runOk, tick, convDone, dmaGo;
  logic [6:0]  divisor;
  logic [4:0]  periods;

  assign wrEn   = psel && penable && pwrite && !pready;
  assign gateOn = perEnable[BIT_CLOCK_GATE];
  assign runOk  = gateOn && modeZero[BIT_START];
  assign dmaGo  = conversionEndEvent && dmaCtrl[BIT_DMA_ENABLE] &&
                  dmaCtrl[BIT_DMA_PENDING] && (dmaMode[3:0] == DMA_SRC_CONV);

  // ==========================================================================
  // conversion clock and length
  always_comb begin
    case (modeZero[5:3])
      3'h0:    divisor = 7'h40;
      3'h1:    divisor = 7'h20;
      3'h2:    divisor = 7'h10;
      3'h3:    divisor = 7'h08;
      3'h4:    divisor = 7'h06;
      3'h5:    divisor = 7'h05;
      3'h6:    divisor = 7'h04;
      default: divisor = 7'h02;
    endcase
    // standard 2 is shorter; prohibited fCLK combinations are left to software
    periods = (modeZero[2:1] == VMODE_STD1) ? PERIODS_STD1 : PERIODS_STD2;
    case (modeOne[1:0])
      TRIG_SRC_TIMER: hwEvent = timerCh1Event;
      TRIG_SRC_RTC:   hwEvent = rtcEvent;
      TRIG_SRC_ITV:   hwEvent = intervalTimerEvent;
      default:        hwEvent = 1'b0;
    endcase
  end

  assign tick     = (state == ST_CONVERT) && (prescale == divisor - 7'h01);
  assign convDone = tick && (periodCount == periods - 5'h01);

  always_ff @(posedge core_clk) begin
    if (!resetn || state != ST_CONVERT || convDone) begin
      prescale    <= 7'h00;
      periodCount <= 5'h00;
    end else if (tick) begin
      prescale    <= 7'h00;
      periodCount <= periodCount + 5'h01;
    end else begin
      prescale    <= prescale + 7'h01;
    end
  end

  // ==========================================================================
  // conversion sequencer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state      <= ST_IDLE;
      slot       <= 2'h0;
      clearStart <= 1'b0;
    end else begin
      clearStart <= 1'b0;
      if (!runOk || clearStart) begin
        state <= ST_IDLE;
        slot  <= inputChannel[1:0];
      end else begin
        case (state)
          ST_IDLE: begin
            slot  <= inputChannel[1:0];
            state <= modeOne[7] ? ST_WAIT_TRIG : ST_CONVERT;
          end
          ST_WAIT_TRIG: begin
            if (hwEvent) begin
              state <= ST_CONVERT;
            end
          end
          default: begin
            if (convDone) begin
              if (modeZero[BIT_SCAN_MODE] && slot != LAST_SLOT) begin
                slot <= slot + 2'h1;
              end else begin
                slot <= inputChannel[1:0];
                if (modeOne[BIT_REPEAT]) begin
                  // one-shot: software mode stops, hardware modes rearm
                  state      <= modeOne[7] ? ST_WAIT_TRIG : ST_IDLE;
                  clearStart <= !modeOne[7];
                end else if (modeOne[7:6] == TRIG_HW_WAIT) begin
                  state <= ST_WAIT_TRIG;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // result capture and event outputs
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      result             <= RST_WORD;
      conversionEndEvent <= 1'b0;
      activeChannel      <= 2'h0;
      converterClockGate <= 1'b0;
    end else begin
      conversionEndEvent <= convDone;
      activeChannel      <= slot;
      converterClockGate <= gateOn;
      if (convDone) begin
        result <= 16'(analogInput[slot]);
      end
    end
  end

  // ==========================================================================
  // dma channel
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ramWrite    <= '0;
      dmaEndEvent <= 1'b0;
      dmaRamAddr  <= RST_WORD;
      dmaCtrl     <= RST_BYTE;
      dmaTransferCount <= RST_WORD;
    end else begin
      ramWrite.valid <= dmaGo;
      dmaEndEvent    <= dmaGo && (dmaTransferCount == 16'h0001);
      if (dmaGo) begin
        ramWrite.addr <= dmaRamAddr;
        ramWrite.data <= result;
      end
      // software writes win over the address and count step: reload is deliberate; the pending clear wins over a control write
      if (wrEn && paddr == OFF_DMA_ADDR) begin
        dmaRamAddr <= pwdata[15:0];
      end else if (dmaGo) begin
        dmaRamAddr <= dmaRamAddr + ADDR_STEP;
      end
      if (wrEn && paddr == OFF_XFER_COUNT) begin
        dmaTransferCount <= pwdata[15:0];
      end else if (dmaGo) begin
        dmaTransferCount <= dmaTransferCount - 16'h0001;
      end
      if (dmaGo && dmaTransferCount == 16'h0001) begin
        dmaCtrl[BIT_DMA_PENDING] <= 1'b0;
      end else if (wrEn && paddr == OFF_DMA_CTRL) begin
        dmaCtrl <= pwdata[7:0] & 8'h81;
      end
    end
  end

  // ==========================================================================
  // control and flag registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      perEnable <= RST_BYTE;
      maskLow <= RST_MASK;
      maskHigh <= RST_MASK;
      flagLow <= RST_BYTE;
      flagHigh <= RST_BYTE;
      modeZero <= RST_BYTE;
      modeOne <= RST_BYTE;
      inputChannel <= RST_BYTE;
      dmaMode <= RST_BYTE;
      irqMask <= 2'h0;
      irqStatus <= 2'h0;
    end else begin
      if (wrEn && paddr == OFF_PER_ENABLE) perEnable <= pwdata[7:0];
      if (wrEn && paddr == OFF_MASK_LOW) maskLow <= pwdata[7:0];
      if (wrEn && paddr == OFF_MASK_HIGH) maskHigh <= pwdata[7:0];
      if (wrEn && paddr == OFF_MODE_ONE) modeOne <= pwdata[7:0];
      if (wrEn && paddr == OFF_CHANNEL) inputChannel <= pwdata[7:0];
      if (wrEn && paddr == OFF_DMA_MODE) dmaMode <= pwdata[7:0];
      if (wrEn && paddr == OFF_IRQ_MASK) irqMask <= pwdata[1:0];
      if (wrEn && paddr == OFF_MODE_ZERO) begin
        modeZero <= pwdata[7:0];
      end else if (clearStart) begin
        modeZero[BIT_START] <= 1'b0;
      end
      if (wrEn && paddr == OFF_FLAG_LOW) flagLow <= pwdata[7:0];
      if (wrEn && paddr == OFF_FLAG_HIGH) flagHigh <= pwdata[7:0];
      // a set in the same cycle as a software clear is kept
      if (conversionEndEvent) begin
        if (PINS_30) flagHigh[BIT_MASK_HIGH] <= 1'b1;
        else flagLow[BIT_MASK_LOW] <= 1'b1;
      end
      irqStatus <= (wrEn && paddr == OFF_IRQ_STATUS) ? irqStatus & ~pwdata[1:0] : irqStatus;
      if (conversionEndEvent) irqStatus[BIT_IRQ_CONV] <= 1'b1;
      if (dmaEndEvent) irqStatus[BIT_IRQ_DMA] <= 1'b1;
    end
  end

  // ==========================================================================
  // interrupt outputs
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      convEndIrq <= 1'b0;
      irq        <= 1'b0;
    end else begin
      convEndIrq <= PINS_30 ? (flagHigh[BIT_MASK_HIGH] && !maskHigh[BIT_MASK_HIGH])
                            : (flagLow[BIT_MASK_LOW] && !maskLow[BIT_MASK_LOW]);
      irq        <= |(irqStatus & irqMask);
    end
  end

  // ==========================================================================
  // apb read and answer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        if (paddr == OFF_XFER_COUNT) prdata <= {16'h0000, dmaTransferCount};
        else if (paddr == OFF_PER_ENABLE) prdata <= {24'h000000, perEnable};
        else if (paddr == OFF_MASK_LOW) prdata <= {24'h000000, maskLow};
        else if (paddr == OFF_FLAG_LOW) prdata <= {24'h000000, flagLow};
        else if (paddr == OFF_MASK_HIGH) prdata <= {24'h000000, maskHigh};
        else if (paddr == OFF_FLAG_HIGH) prdata <= {24'h000000, flagHigh};
        else if (paddr == OFF_MODE_ZERO) prdata <= {24'h000000, modeZero};
        else if (paddr == OFF_MODE_ONE) prdata <= {24'h000000, modeOne};
        else if (paddr == OFF_CHANNEL) prdata <= {24'h000000, inputChannel};
        else if (paddr == OFF_DMA_CTRL) prdata <= {24'h000000, dmaCtrl};
        else if (paddr == OFF_DMA_MODE) prdata <= {24'h000000, dmaMode};
        else if (paddr == OFF_DMA_ADDR) prdata <= {16'h0000, dmaRamAddr};
        else if (paddr == OFF_RESULT) prdata <= {16'h0000, result};
        else if (paddr == OFF_IRQ_STATUS) prdata <= {30'h0, irqStatus};
        else if (paddr == OFF_IRQ_MASK) prdata <= {30'h0, irqMask};
        else pslverr <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // assertions
  sequence s_dma_step;
    ramWrite.valid ##0 ($past(dmaTransferCount) != dmaTransferCount);
  endsequence

  property p_gate_stop;
    @(posedge core_clk) disable iff (!resetn)
      !gateOn |=> state == ST_IDLE;
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("gate off kept converter running");

  property p_mask_block;
    @(posedge core_clk) disable iff (!resetn)
      (!PINS_30 && maskLow[BIT_MASK_LOW] && $stable(maskLow)) |=> !convEndIrq;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked interrupt delivered");
  property p_flag_set;
    @(posedge core_clk) disable iff (!resetn)
      conversionEndEvent |=> (PINS_30 ? flagHigh[BIT_MASK_HIGH] : flagLow[BIT_MASK_LOW]);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("request flag not raised");
  property p_scan_step;
    @(posedge core_clk) disable iff (!resetn)
      (runOk && convDone && modeZero[BIT_SCAN_MODE] && slot != LAST_SLOT)
        |=> slot == $past(slot) + 2'h1;
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("scan slot did not advance");

  property p_divide;
    @(posedge core_clk) disable iff (!resetn)
      state == ST_CONVERT |-> prescale < divisor;
  endproperty
  a_divide: assert property (p_divide) else $error("prescaler passed divisor");
  logic [10:0] convCycles;
  always_ff @(posedge core_clk) begin
    convCycles <= (!resetn || state != ST_CONVERT || convDone) ? 11'h000 : convCycles + 11'h001;
  end
  property p_conv_len;
    @(posedge core_clk) disable iff (!resetn)
      convDone |-> convCycles == 11'(divisor * periods - 1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_hw_wait;
    @(posedge core_clk) disable iff (!resetn)
      (state == ST_WAIT_TRIG && !hwEvent && runOk && $stable(modeZero)) |=> state != ST_CONVERT;
  endproperty
  a_hw_wait: assert property (p_hw_wait) else $error("converted without trigger");
  property p_sw_mode;
    @(posedge core_clk) disable iff (!resetn)
      (state == ST_IDLE && runOk && !clearStart && !modeOne[7]) |=> state == ST_CONVERT;
  endproperty
  a_sw_mode: assert property (p_sw_mode) else $error("software trigger did not start");
  property p_dma_move;
    @(posedge core_clk) disable iff (!resetn)
      (dmaGo && !(psel && pwrite)) |=> s_dma_step ##0 ramWrite.addr == $past(dmaRamAddr);
  endproperty
  a_dma_move: assert property (p_dma_move) else $error("dma transfer not performed");
  property p_dma_hold;
    @(posedge core_clk) disable iff (!resetn)
      (conversionEndEvent && !dmaCtrl[BIT_DMA_PENDING]) |=> !ramWrite.valid;
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("dma moved while not pending");

endmodule

// *** verilog/amt_pkg.sv ***
// Purpose: shared constants and types for the converter mode and trigger control
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   all register offsets are byte addresses

package amt_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFF_XFER_COUNT  = 8'h00;
  localparam logic [7:0] OFF_PER_ENABLE  = 8'h04;
  localparam logic [7:0] OFF_MASK_LOW    = 8'h08;
  localparam logic [7:0] OFF_FLAG_LOW    = 8'h0c;
  localparam logic [7:0] OFF_MASK_HIGH   = 8'h10;
  localparam logic [7:0] OFF_FLAG_HIGH   = 8'h14;
  localparam logic [7:0] OFF_MODE_ZERO   = 8'h18;
  localparam logic [7:0] OFF_MODE_ONE    = 8'h1c;
  localparam logic [7:0] OFF_CHANNEL     = 8'h20;
  localparam logic [7:0] OFF_DMA_CTRL    = 8'h24;
  localparam logic [7:0] OFF_DMA_MODE    = 8'h28;
  localparam logic [7:0] OFF_DMA_ADDR    = 8'h2c;
  localparam logic [7:0] OFF_RESULT      = 8'h30;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h34;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h38;

  // ==========================================================================
  // field positions
  localparam int BIT_CLOCK_GATE   = 5;
  localparam int BIT_MASK_LOW     = 2;
  localparam int BIT_MASK_HIGH    = 0;
  localparam int BIT_START        = 7;
  localparam int BIT_SCAN_MODE    = 6;
  localparam int BIT_REPEAT       = 5;
  localparam int BIT_DMA_ENABLE   = 7;
  localparam int BIT_DMA_PENDING  = 0;
  localparam int BIT_IRQ_CONV     = 0;
  localparam int BIT_IRQ_DMA      = 1;

  // ==========================================================================
  // reset values and codes
  localparam logic [7:0]  RST_MASK        = 8'hff;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [3:0]  DMA_SRC_CONV    = 4'h1;
  localparam logic [1:0]  TRIG_SRC_NONE   = 2'h0;
  localparam logic [1:0]  TRIG_SRC_TIMER  = 2'h1;
  localparam logic [1:0]  TRIG_SRC_RTC    = 2'h2;
  localparam logic [1:0]  TRIG_SRC_ITV    = 2'h3;
  localparam logic [1:0]  TRIG_HW_WAIT    = 2'h3;
  localparam logic [1:0]  VMODE_STD1      = 2'h0;
  localparam logic [4:0]  PERIODS_STD1    = 5'h13;
  localparam logic [4:0]  PERIODS_STD2    = 5'h11;
  localparam logic [1:0]  LAST_SLOT       = 2'h3;
  localparam logic [15:0] ADDR_STEP       = 16'h0002;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_CONVERT
  } amt_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } amt_ram_wr_t;

endpackage

// *** verification/amt_ram_model.sv ***
// Purpose: on-chip ram behind the dma write port, logs the first 16 words it takes and counts all
// Assumes: one write per valid pulse, 16-bit words
// Notes:   log holds the first 16 writes; later ones are counted only

`timescale 1ns/10ps

module amt_ram_model
  import amt_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // write port from the dma
  input  wire amt_ram_wr_t ramWrite
);
  // ==========================================================================
  // write log
  logic [15:0] addrLog [0:15];
  logic [15:0] dataLog [0:15];
  int          wrCount;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wrCount <= 0;
    end else if (ramWrite.valid === 1'b1) begin
      if (wrCount < 16) begin
        addrLog[wrCount] <= ramWrite.addr;
        dataLog[wrCount] <= ramWrite.data;
      end
      wrCount <= wrCount + 1;
    end
  end
endmodule

// *** verification/tb_adc_mode_trigger_control.sv ***
// Purpose: self-checking bench for the converter mode and trigger control
// Assumes: apb master tasks, 10-bit 4-channel builds with low and high flag placement
// Notes:   conversion times are accepted within a few cycles of div*periods

`timescale 1ns/10ps

module tb_adc_mode_trigger_control
  import amt_pkg::*;
;
  // ==========================================================================
  // signals
  logic            core_clk  = 1'b0;
  logic            resetn    = 1'b0;
  logic            psel      = 1'b0;
  logic            penable   = 1'b0;
  logic            pwrite    = 1'b0;
  logic [7:0]      paddr     = 8'h00;
  logic [31:0]     pwdata    = 32'h0;
  logic [3:0][9:0] ain       = {10'h3f4, 10'h203, 10'h152, 10'h0a1};
  logic [2:0]      trig      = 3'h0;
  logic            pready;
  logic            pslverr;
  logic [31:0]     prdata;
  logic            clkGate;
  logic            convEnd;
  logic            convIrq;
  logic            dmaEnd;
  logic            irq;
  logic            irq30;
  logic [1:0]      actCh;
  amt_ram_wr_t     ramWr;
  logic [31:0]     rd;
  logic            er;
  int              errors    = 0;
  int              num_checks = 0;
  int              i, t, s, n, div, per;
  int              divTab [8] = '{64, 32, 16, 8, 6, 5, 4, 2};

  always #12.5 core_clk = ~core_clk;

  amt_control #(.RES_BITS(10), .CHANNELS(4), .PINS_30(1'b0)) DUT (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .analogInput(ain),
    .timerCh1Event(trig[0]), .rtcEvent(trig[1]), .intervalTimerEvent(trig[2]),
    .converterClockGate(clkGate), .conversionEndEvent(convEnd),
    .convEndIrq(convIrq), .activeChannel(actCh), .ramWrite(ramWr),
    .dmaEndEvent(dmaEnd), .irq(irq));

  amt_control #(.RES_BITS(10), .CHANNELS(4), .PINS_30(1'b1)) DUT30 (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .pslverr(), .prdata(),
    .analogInput(ain), .timerCh1Event(trig[0]), .rtcEvent(trig[1]),
    .intervalTimerEvent(trig[2]), .converterClockGate(), .conversionEndEvent(),
    .convEndIrq(irq30), .activeChannel(), .ramWrite(), .dmaEndEvent(), .irq());

  amt_ram_model u_ram (.core_clk(core_clk), .resetn(resetn), .ramWrite(ramWr));

  // ==========================================================================
  // tasks
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // holds the request until pready is sampled high; a stuck slave ends the run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20 && pready !== 1'b1) begin
      check("pready", pready, 1'b1);
      print_verdict;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // sel 0 waits for conversion end, 1 for dma end; a required event that never comes ends the run
  task waitEv(input logic sel, input int lim, input logic must, output int cnt);
    cnt = 0;
    while (cnt < lim && (sel ? dmaEnd : convEnd) !== 1'b1) begin
      @(posedge core_clk);
      cnt++;
    end
    if (must && cnt >= lim) begin
      check("event", 1'b0, 1'b1);
      print_verdict;
    end
  endtask

  task pulse(input int b);
    @(posedge core_clk);
    trig <= 3'h1 << b;
    @(posedge core_clk);
    trig <= 3'h0;
  endtask

  task settle;
    repeat (3) @(posedge core_clk);
  endtask

  // ==========================================================================
  // sequence
  initial begin
    #2500000;
    check("watchdog", 1'b0, 1'b1);
    print_verdict;
  end

  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    for (i = 0; i < 12; i++) begin
      rdc(8'(i * 4), (i == 2 || i == 4) ? 32'hff : 32'h0, "reset value");
    end
    apb(1'b0, 8'h3c, 32'h0);
    check("unmapped error", er, 1'b1);
    check("unmapped data", rd, 32'h0);
    wr(OFF_XFER_COUNT, 32'h0001_0028);
    rdc(OFF_XFER_COUNT, 32'h28, "transfer count");
    $display("test registers done");

    wr(OFF_PER_ENABLE, 32'h20);
    settle;
    check("clock gate on", clkGate, 1'b1);
    wr(OFF_MODE_ONE, 32'h20);
    wr(OFF_MODE_ZERO, 32'h80);
    wr(OFF_PER_ENABLE, 32'h0);
    waitEv(1'b0, 1400, 1'b0, n);
    check("gated conversion", n, 1400);
    check("clock gate off", clkGate, 1'b0);
    wr(OFF_MODE_ZERO, 32'h0);
    wr(OFF_PER_ENABLE, 32'h20);
    $display("test clock gate done");

    // every divider under both voltage modes, one-shot software start
    wr(OFF_CHANNEL, 32'h2);
    for (i = 0; i < 16; i++) begin
      div = divTab[i % 8];
      per = (i < 8) ? 19 : 17;
      wr(OFF_MODE_ZERO, 32'h80 | ((i % 8) << 3) | ((i / 8) << 1));
      waitEv(1'b0, 1500, 1'b1, n);
      check("conversion time", (n + 2 >= div * per) && (n <= div * per + 3), 1'b1);
      settle;
    end
    rdc(OFF_MODE_ZERO, 32'h3a, "one-shot start bit");
    rdc(OFF_RESULT, {22'h0, ain[2]}, "select result");
    $display("test conversion time done");

    // wrong source must not start, right source must
    for (t = 2; t < 4; t++) begin
      for (s = 1; s < 4; s++) begin
        wr(OFF_MODE_ONE, (t << 6) | 32'h20 | s);
        wr(OFF_MODE_ZERO, 32'hba);
        pulse(s % 3);
        waitEv(1'b0, 80, 1'b0, n);
        check("wrong trigger", n, 80);
        pulse(s - 1);
        waitEv(1'b0, 80, 1'b1, n);
        check("right trigger", n < 80, 1'b1);
        wr(OFF_MODE_ZERO, 32'h0);
      end
    end
    // sequential: no-wait keeps converting, wait mode needs a trigger each time
    for (t = 2; t < 4; t++) begin
      wr(OFF_MODE_ONE, (t << 6) | 32'h1);
      wr(OFF_MODE_ZERO, 32'hba);
      pulse(0);
      waitEv(1'b0, 80, 1'b1, n);
      check("active channel", actCh, 2'h2);
      @(posedge core_clk);
      waitEv(1'b0, 80, 1'b0, n);
      check("sequential rerun", n < 80, t == 2);
      wr(OFF_MODE_ZERO, 32'h0);
    end
    $display("test triggers done");

    wr(OFF_IRQ_STATUS, 32'h3);
    wr(OFF_FLAG_LOW, 32'h0);
    wr(OFF_MODE_ONE, 32'h0);
    wr(OFF_CHANNEL, 32'h0);
    wr(OFF_XFER_COUNT, 32'h4);
    wr(OFF_DMA_MODE, {28'h0, DMA_SRC_CONV});
    wr(OFF_DMA_ADDR, 32'h100);
    wr(OFF_DMA_CTRL, 32'h81);
    wr(OFF_MODE_ZERO, 32'hfa);
    waitEv(1'b1, 400, 1'b1, n);
    wr(OFF_MODE_ZERO, 32'h0);
    for (i = 0; i < 4; i++) begin
      check("ram address", u_ram.addrLog[i], 32'h100 + 2 * i);
      check("ram data", u_ram.dataLog[i], ain[i]);
    end
    check("ram writes", u_ram.wrCount, 4);
    rdc(OFF_XFER_COUNT, 32'h0, "count at end");
    rdc(OFF_DMA_CTRL, 32'h80, "pending cleared");
    rdc(OFF_FLAG_LOW, 32'h4, "request flag");
    check("masked irq", convIrq, 1'b0);
    check("30-pin irq masked", irq30, 1'b0);
    wr(OFF_MASK_LOW, 32'hfb);
    settle;
    check("unmasked irq", convIrq, 1'b1);
    wr(OFF_FLAG_LOW, 32'h0);
    settle;
    check("flag cleared irq", convIrq, 1'b0);
    wr(OFF_MASK_HIGH, 32'hfe);
    settle;
    check("30-pin irq", irq30, 1'b1);
    check("low irq ignores high mask", convIrq, 1'b0);
    wr(OFF_FLAG_HIGH, 32'h0);
    settle;
    check("30-pin flag cleared", irq30, 1'b0);
    rdc(OFF_IRQ_STATUS, 32'h3, "irq status");
    wr(OFF_IRQ_MASK, 32'h2);
    settle;
    check("dma end irq", irq, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h2);
    settle;
    check("irq after clear", irq, 1'b0);
    rdc(OFF_IRQ_STATUS, 32'h1, "status after clear");
    $display("test dma scan done");
    print_verdict;
  end
endmodule
